// ---- emb_mem.v ----
`timescale 1ns/100ps
`include "emb_mem_regs.vh"
// How it works
// RULE1 - storage is exactly 4096 bits whatever the organisation
// RULE2 - function select: read-write, read-only, fifo, or lookup table
// RULE3 - data words up to 16 bits wide per access
// RULE4 - single-port scheme shares one address; dual-port splits write and read
// RULE5 - in dual-port, write and read sections follow their own clocks
// RULE6 - each section has a synchronous enable; disabled, its edges are ignored
// RULE7 - inputs are captured in registers, read data leaves through a register
// RULE8 - alternative scheme: input registers on clock a, output register on b
// RULE9 - lookup mode returns the pattern loaded at configuration time
// RULE10 - one block covers any 8-input, 16-output function
// RULE11 - two simultaneous two-way ports need two blocks in user logic
// RULE12 - wider or deeper memories combine blocks; each block stands alone
// RULE13 - depth is 4096 divided by width: 4096x1 down to 256x16
// RULE14 - read and write of one address on one edge returns old data
module emb_mem (
  input  wire                   mclk,
  input  wire                   nrst,
  input  wire                   ce,
  input  wire [1:0]             cfg_func,
  input  wire [1:0]             cfg_scheme,
  input  wire [`EMB_SELW-1:0]   cfg_width,
  input  wire                   clk_a_pin,
  input  wire                   clk_b_pin,
  input  wire                   ena_a,
  input  wire                   ena_b,
  input  wire [`EMB_AW-1:0]     wr_addr,
  input  wire [`EMB_MAXW-1:0]   wr_data,
  input  wire                   wr_we,
  input  wire [`EMB_AW-1:0]     rd_addr,
  input  wire                   rd_req,
  input  wire [`EMB_LUT_IN-1:0] lut_in,
  input  wire                   init_load,
  input  wire [`EMB_WIDX-1:0]   init_addr,
  input  wire [`EMB_MAXW-1:0]   init_data,
  output reg  [`EMB_MAXW-1:0]   rd_data,
  output reg                    rd_valid,
  output reg                    fifo_full,
  output reg                    fifo_empty,
  output reg  [`EMB_LVLW-1:0]   fifo_level
);
  // 256 words of 16 bits hold all 4096 bits in every organisation
  reg [`EMB_MAXW-1:0] mem [0:`EMB_WORDS-1]; // RULE1

  function [`EMB_WIDX-1:0] word_idx;
    input [`EMB_AW-1:0]   a;
    input [`EMB_SELW-1:0] s;
    reg   [`EMB_AW-1:0]   t;
    begin
      t        = a >> (3'h4 - s);
      word_idx = t[`EMB_WIDX-1:0];
    end
  endfunction

  function [`EMB_LANEW-1:0] lane_of;
    input [`EMB_AW-1:0]   a;
    input [`EMB_SELW-1:0] s;
    reg   [`EMB_AW-1:0]   t;
    begin
      t       = a & ~(12'hfff << (3'h4 - s));
      lane_of = t[`EMB_LANEW-1:0];
    end
  endfunction

  // section clocks arrive from other domains; each becomes a one-cycle tick
  wire [1:0] sec_pin = {clk_b_pin, clk_a_pin};
  wire [1:0] tick;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      emb_edge_sync u_sync (
        .mclk (mclk),
        .nrst (nrst),
        .ce   (ce),
        .pin  (sec_pin[gi]),
        .rise (tick[gi])
      );
    end
  endgenerate

  wire is_rom  = (cfg_func == `EMB_FN_ROM);
  wire is_fifo = (cfg_func == `EMB_FN_FIFO);
  wire is_lut  = (cfg_func == `EMB_FN_LUT);

  // lookup mode is always 256x16; oversize width codes clamp to 16 bits
  wire [`EMB_SELW-1:0] sel = is_lut ? `EMB_W16 :                // RULE10
                             (cfg_width > `EMB_W16) ? `EMB_W16 : // RULE3
                             cfg_width;
  wire [`EMB_LVLW-1:0] depth = `EMB_DEPTH_MAX >> sel;            // RULE13
  wire [`EMB_AW-1:0]   dmask = depth[`EMB_AW-1:0] - 12'h001;

  // section strobes per clocking scheme
  reg in_t;
  reg rin_t;
  reg out_t;
  reg shared;
  always @* begin
    case (cfg_scheme)
      `EMB_SC_DUAL: begin
        in_t   = tick[0] & ena_a;                                // RULE5
        rin_t  = tick[1] & ena_b;                                // RULE6
        out_t  = tick[1] & ena_b;
        shared = 1'b0;                                           // RULE4
      end
      `EMB_SC_INOUT: begin
        in_t   = tick[0] & ena_a;                                // RULE8
        rin_t  = tick[0] & ena_a;
        out_t  = tick[1] & ena_b;
        shared = 1'b0;
      end
      default: begin
        in_t   = ena_a;
        rin_t  = ena_a;
        out_t  = ena_a;
        shared = 1'b1;                                           // RULE4
      end
    endcase
  end

  // fifo occupancy
  wire full_now  = (fifo_level == depth);
  wire empty_now = (fifo_level == `EMB_RST_LVL);
  wire push = is_fifo & in_t & wr_we & ~full_now;
  wire pop  = is_fifo & rin_t & rd_req & ~empty_now;
  wire [`EMB_LVLW-1:0] next_level =
    fifo_level + {12'h000, push} - {12'h000, pop};

  reg [`EMB_AW-1:0] wptr;
  reg [`EMB_AW-1:0] rptr;

  // read-only and lookup contents only change through init_load
  wire write_ok = ~is_rom & ~is_lut & (is_fifo ? push : wr_we);  // RULE2

  // input register stage
  reg                  wgo;
  reg [`EMB_AW-1:0]    wa_q;
  reg [`EMB_MAXW-1:0]  wd_q;
  reg [`EMB_SELW-1:0]  wsel_q;
  reg [`EMB_AW-1:0]    ra_q;
  reg [`EMB_SELW-1:0]  rsel_q;
  reg                  rpop_q;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wgo    <= 1'b0;
      wa_q   <= `EMB_RST_ADDR;
      wd_q   <= `EMB_RST_DATA;
      wsel_q <= `EMB_W16;
      ra_q   <= `EMB_RST_ADDR;
      rsel_q <= `EMB_W16;
      rpop_q <= 1'b0;
    end else if (ce) begin
      wgo <= in_t & write_ok;
      if (in_t) begin                                            // RULE7
        wa_q   <= is_fifo ? wptr : wr_addr;
        wd_q   <= wr_data;
        wsel_q <= sel;
      end
      if (rin_t) begin                                           // RULE7
        if (is_lut)
          ra_q <= {4'h0, lut_in};                                // RULE9
        else if (is_fifo)
          ra_q <= rptr;
        else if (shared)
          ra_q <= wr_addr;
        else
          ra_q <= rd_addr;
        rsel_q <= sel;
        rpop_q <= pop;
      end else if (out_t) begin
        rpop_q <= 1'b0;
      end
    end
  end

  // fifo pointers wrap at the configured depth
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wptr       <= `EMB_RST_ADDR;
      rptr       <= `EMB_RST_ADDR;
      fifo_level <= `EMB_RST_LVL;
      fifo_full  <= 1'b0;
      fifo_empty <= 1'b1;
    end else if (ce) begin
      if (push)
        wptr <= (wptr + 12'h001) & dmask;
      if (pop)
        rptr <= (rptr + 12'h001) & dmask;
      fifo_level <= next_level;
      fifo_full  <= (next_level == depth);
      fifo_empty <= (next_level == `EMB_RST_LVL);
    end
  end

  // lane handling for narrow words
  wire [`EMB_WIDX-1:0]  widx  = word_idx(wa_q, wsel_q);
  wire [`EMB_WIDX-1:0]  ridx  = word_idx(ra_q, rsel_q);
  wire [`EMB_LANEW-1:0] wlane = lane_of(wa_q, wsel_q);
  wire [`EMB_LANEW-1:0] rlane = lane_of(ra_q, rsel_q);
  wire [`EMB_MAXW-1:0]  wmask;
  wire [`EMB_MAXW-1:0]  wbits;
  wire [`EMB_MAXW-1:0]  rfield;

  emb_lane u_lane (
    .wsel  (wsel_q),
    .wlane (wlane),
    .wdata (wd_q),
    .rsel  (rsel_q),
    .rlane (rlane),
    .rword (mem[ridx]),
    .wmask (wmask),
    .wbits (wbits),
    .rdata (rfield)
  );

  // init_load wins a collision: configuration loading precedes user traffic
  always @(posedge mclk) begin
    if (ce) begin
      if (init_load)
        mem[init_addr] <= init_data;                             // RULE9
      else if (wgo)
        mem[widx] <= (mem[widx] & ~wmask) | wbits;               // RULE13
    end
  end

  // output register samples the array before this edge's write lands
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data  <= `EMB_RST_DATA;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= out_t & (~is_fifo | rpop_q);
      if (out_t)
        rd_data <= rfield;                                       // RULE14
    end
  end
endmodule

// ---- emb_mem_regs.vh ----
`ifndef EMB_MEM_REGS_VH
`define EMB_MEM_REGS_VH

// storage geometry
`define EMB_BITS      4096
`define EMB_AW        12
`define EMB_MAXW      16
`define EMB_WORDS     256
`define EMB_WIDX      8
`define EMB_LANEW     4
`define EMB_LUT_IN    8
`define EMB_LVLW      13
`define EMB_DEPTH_MAX 13'h1000

// word width select: width = 1 << sel, depth = 4096 >> sel
`define EMB_SELW      3
`define EMB_W1        3'h0
`define EMB_W2        3'h1
`define EMB_W4        3'h2
`define EMB_W8        3'h3
`define EMB_W16       3'h4

// memory function
`define EMB_FN_RAM    2'h0
`define EMB_FN_ROM    2'h1
`define EMB_FN_FIFO   2'h2
`define EMB_FN_LUT    2'h3

// clocking scheme
`define EMB_SC_SINGLE 2'h0
`define EMB_SC_DUAL   2'h1
`define EMB_SC_INOUT  2'h2

// reset values
`define EMB_RST_DATA  16'h0000
`define EMB_RST_ADDR  12'h000
`define EMB_RST_LVL   13'h0000

`endif

// ---- emb_edge_sync.v ----
`timescale 1ns/100ps
module emb_edge_sync (
  input  wire mclk,
  input  wire nrst,
  input  wire ce,
  input  wire pin,
  output reg  rise
);
  reg meta;
  reg stable;
  reg last;

  // meta feeds only stable; the edge is taken from the settled pair
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
      rise   <= 1'b0;
    end else if (ce) begin
      meta   <= pin;
      stable <= meta;
      last   <= stable;
      rise   <= stable & ~last;
    end
  end
endmodule

// ---- emb_lane.v ----
`timescale 1ns/100ps
`include "emb_mem_regs.vh"
module emb_lane (
  input  wire [`EMB_SELW-1:0]  wsel,
  input  wire [`EMB_LANEW-1:0] wlane,
  input  wire [`EMB_MAXW-1:0]  wdata,
  input  wire [`EMB_SELW-1:0]  rsel,
  input  wire [`EMB_LANEW-1:0] rlane,
  input  wire [`EMB_MAXW-1:0]  rword,
  output wire [`EMB_MAXW-1:0]  wmask,
  output wire [`EMB_MAXW-1:0]  wbits,
  output wire [`EMB_MAXW-1:0]  rdata
);
  function [`EMB_MAXW-1:0] field_mask;
    input [`EMB_SELW-1:0] s;
    reg   [`EMB_MAXW:0]   one;
    begin
      one        = 17'h00001 << (5'h01 << s);
      field_mask = one[`EMB_MAXW-1:0] - 16'h0001;
    end
  endfunction

  function [`EMB_LANEW-1:0] bit_offset;
    input [`EMB_LANEW-1:0] lane;
    input [`EMB_SELW-1:0]  s;
    reg   [7:0]            t;
    begin
      t          = {4'h0, lane} << s;
      bit_offset = t[`EMB_LANEW-1:0];
    end
  endfunction

  wire [`EMB_LANEW-1:0] woff = bit_offset(wlane, wsel);
  wire [`EMB_LANEW-1:0] roff = bit_offset(rlane, rsel);

  assign wmask = field_mask(wsel) << woff;
  assign wbits = (wdata & field_mask(wsel)) << woff;
  assign rdata = (rword >> roff) & field_mask(rsel);
endmodule

// ---- emb_user_clk.sv ----
`timescale 1ns/100ps
module emb_user_clk #(
  parameter [3:0] HALF = 4'h3
) (
  input  wire mclk,
  input  wire run,
  output reg  pin = 1'b0
);
  reg [3:0] cnt = 4'h0;
  // parked low outside a burst so no stray section edge reaches the block
  always @(posedge mclk) begin
    if (!run || cnt == HALF - 4'h1) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
    if (!run) pin <= 1'b0;
    else if (cnt == HALF - 4'h1) pin <= ~pin;
  end
endmodule

// ---- emb_mem_assertions.sv ----
`timescale 1ns/100ps
module emb_chk (
  input wire        mclk,
  input wire        nrst,
  input wire        ce,
  input wire        ena_a,
  input wire        wr_we,
  input wire        rd_req,
  input wire [1:0]  cfg_func,
  input wire [1:0]  cfg_scheme,
  input wire [15:0] rd_data,
  input wire        rd_valid,
  input wire        fifo_full,
  input wire        fifo_empty,
  input wire [12:0] fifo_level
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire go  = ce && ena_a && cfg_scheme == 2'h0;
  wire fq  = cfg_func == 2'h2;
  wire ram = go && cfg_func == 2'h0;
  sequence s_rd;
    ram ##1 ram;
  endsequence
  sequence s_pop;
    go && fq && rd_req && !wr_we && !fifo_empty;
  endsequence
  property p_lat;
    s_rd |=> rd_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("read late");
  property p_hold;
    ce && !ena_a && cfg_scheme == 2'h0 && !fq |=> !rd_valid && $stable(rd_data);
  endproperty
  a_hold: assert property (p_hold) else $error("disabled moved");
  property p_frz;
    !ce |=> $stable(rd_data) && $stable(rd_valid) && $stable(fifo_level);
  endproperty
  a_frz: assert property (p_frz) else $error("not frozen");
  property p_emp;
    fifo_empty == (fifo_level == 13'h0000);
  endproperty
  a_emp: assert property (p_emp) else $error("empty flag");
  property p_push;
    go && fq && wr_we && !rd_req && !fifo_full
      |=> fifo_level == $past(fifo_level) + 13'h0001;
  endproperty
  a_push: assert property (p_push) else $error("push count");
  property p_pop;
    s_pop |=> fifo_level == $past(fifo_level) - 13'h0001;
  endproperty
  a_pop: assert property (p_pop) else $error("pop count");
  property p_popd;
    s_pop ##1 go |=> rd_valid;
  endproperty
  a_popd: assert property (p_popd) else $error("pop data late");
  property p_full;
    go && fq && fifo_full && wr_we && !rd_req |=> fifo_full && $stable(fifo_level);
  endproperty
  a_full: assert property (p_full) else $error("push when full");
endmodule
bind emb_mem emb_chk u_emb_chk (.mclk, .nrst, .ce, .ena_a, .wr_we, .rd_req,
  .cfg_func, .cfg_scheme, .rd_data, .rd_valid, .fifo_full, .fifo_empty,
  .fifo_level);

// ---- emb_mem_tb.sv ----
`timescale 1ns/100ps
module emb_mem_tb;
  reg          mclk, nrst, ce, ena_a, ena_b, wr_we, rd_req, init_load;
  reg          run_a, run_b, ce_q, hv;
  reg  [1:0]   cfg_func, cfg_scheme;
  reg  [2:0]   cfg_width, pa;
  reg  [7:0]   lut_in, init_addr;
  reg  [11:0]  wr_addr, rd_addr;
  reg  [15:0]  wr_data, init_data, r, e;
  reg  [15:0]  mdl [0:7];
  wire         clk_a_pin, clk_b_pin, rd_valid, fifo_full, fifo_empty;
  wire [15:0]  rd_data;
  wire [12:0]  fifo_level;
  logic [15:0] exq[$], fq[$];
  int          failures, comparisons, i, n;
  emb_mem u_emb_mem (.mclk, .nrst, .ce, .cfg_func, .cfg_scheme, .cfg_width,
    .clk_a_pin, .clk_b_pin, .ena_a, .ena_b, .wr_addr, .wr_data, .wr_we,
    .rd_addr, .rd_req, .lut_in, .init_load, .init_addr, .init_data,
    .rd_data, .rd_valid, .fifo_full, .fifo_empty, .fifo_level);
  emb_user_clk #(.HALF(4'h3)) u_clk_a (.mclk, .run(run_a), .pin(clk_a_pin));
  emb_user_clk #(.HALF(4'h5)) u_clk_b (.mclk, .run(run_b), .pin(clk_b_pin));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input string nm, input [15:0] x, input [15:0] y);
    comparisons++;
    if (x !== y) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, x, y);
    end
  endtask
  task summarize;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task step;
    @(posedge mclk);
    r = nx(r);
  endtask
  task idle(input int k);
    step;
    {ce, ena_a, ena_b, wr_we, rd_req, init_load} <= 6'h20;
    repeat (k) @(posedge mclk);
  endtask
  task rst;
    nrst <= 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    // reset parks the read register on word 0; the first enabled edge shows it
    hv = 1'b1;
    pa = 3'h0;
  endtask
  // a frozen pulse under ce low must not be taken as a second result
  always @(posedge mclk) begin
    if (rd_valid === 1'b1 && ce_q) begin
      e = exq.size() > 0 ? exq.pop_front() : 16'hxxxx;
      chk("rd_data", e, rd_data);
    end
    ce_q <= ce;
  end
  task ram(input [1:0] f);
    reg        pw;
    reg [2:0]  pwa;
    reg [15:0] pwd;
    pw = 1'b0;
    cfg_func <= f;
    for (i = 0; i < 40; i++) begin
      step;
      ce <= r[9] | r[3];
      ena_a <= 1'b1;
      wr_we <= r[7];
      wr_addr <= {9'h0, r[2:0]};
      lut_in <= {5'h0, r[2:0]};
      wr_data <= r;
      if (r[9] | r[3]) begin
        if (hv) exq.push_back(mdl[pa]);
        if (pw) mdl[pwa] = pwd;
        pa = r[2:0];
        hv = 1'b1;
        pw = r[7] && f == 2'h0;
        pwa = r[2:0];
        pwd = r;
      end
    end
    if (pw) mdl[pwa] = pwd;
    idle(3);
  endtask
  task dual(input [1:0] s, input eb);
    cfg_scheme <= s;
    cfg_func <= 2'h0;
    {wr_addr, rd_addr} <= {2{12'h003}};
    wr_data <= r;
    {ena_a, wr_we, run_a} <= 3'h7;
    repeat (20) @(posedge mclk);
    run_a <= 1'b0;
    repeat (8) @(posedge mclk);
    {ena_a, wr_we, ena_b, run_b} <= {2'h0, eb, 1'b1};
    mdl[3] = wr_data;
    // the in/out scheme shows its one captured address at both read ticks
    if (eb && (s != 2'h1 || hv))
      exq.push_back(s == 2'h1 ? mdl[pa] : mdl[3]);
    if (eb) exq.push_back(mdl[3]);
    repeat (20) @(posedge mclk);
    run_b <= 1'b0;
    idle(8);
    cfg_scheme <= 2'h0;
    if (eb) pa = 3'h3;
    if (eb) hv = s == 2'h1;
  endtask
  task fifo(input [2:0] w);
    rst;
    n = 4096 >> w;
    cfg_func <= 2'h2;
    cfg_width <= w;
    for (i = 0; i <= n; i++) begin
      step;
      {ena_a, wr_we} <= 2'h3;
      wr_data <= r;
      if (i < n) fq.push_back(r & ~(16'hffff << (5'h1 << w)));
    end
    idle(1);
    chk("fifo_level", n[15:0], {3'h0, fifo_level});
    chk("fifo_full", 16'h1, {15'h0, fifo_full});
    for (i = 0; i <= n; i++) begin
      step;
      {ena_a, rd_req} <= 2'h3;
      if (i < n) exq.push_back(fq.pop_front());
    end
    idle(3);
    chk("fifo_empty", 16'h1, {15'h0, fifo_empty});
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    summarize;
  end
  initial begin
    {ce, ena_a, ena_b, wr_we, rd_req, init_load, run_a, run_b} = 8'h80;
    {cfg_func, cfg_scheme, wr_addr, rd_addr, wr_data} = '0;
    {lut_in, init_addr, init_data, ce_q, hv} = '0;
    {nrst, cfg_width, r} = {1'b0, 3'h4, 16'h0011};
    rst;
    for (i = 0; i < 8; i++) begin
      step;
      {init_load, init_addr, init_data} <= {1'b1, i[7:0], r};
      mdl[i] = r;
    end
    idle(2);
    ram(2'h0);
    ram(2'h1);
    ram(2'h3);
    dual(2'h1, 1'b1);
    dual(2'h1, 1'b0);
    dual(2'h2, 1'b1);
    for (int w = 0; w < 5; w++) fifo(w[2:0]);
    idle(5);
    chk("pending", 16'h0, 16'(exq.size()));
    summarize;
  end
endmodule
